// *** core/mfr_host.sv ***
/*
  host controller for serial flash fast reads (dual i/o, dual out, quad out, quad i/o)
  with continuous-read mode; makes chip select and sck itself, two-entry buffer on read data.
  assumes io inputs are asynchronous pins, the command port is on sys_clk_in, and the
  flash's dummy setting matches dual_dummy_in / quad_dummy_in.
*/
`timescale 1ns/1ps
`include "mfr_regs.svh"
module mfr_host #(
    parameter int SCK_HALF = `MFR_SCK_HALF_DEF            // sys clocks per sck half, at least 3
) (
    input  wire logic              sys_clk_in,            // 10 mhz system clock
    input  wire logic              sys_rst_in,            // async reset, high
    input  wire logic              clk_en_in,             // freezes all state when low
    input  wire logic              cmd_valid_in,          // read request
    output logic                   cmd_ready_out,         // request taken when both high
    input  wire mfr_pkg::mfr_kind_t cmd_kind_in,          // read kind
    input  wire logic [23:0]       cmd_addr_in,           // start address
    input  wire logic [15:0]       cmd_len_in,            // bytes to read
    input  wire logic              cmd_cont_in,           // ask for continuous-read mode
    input  wire logic [3:0]        dual_dummy_in,         // dual i/o dummy clocks
    input  wire logic [3:0]        quad_dummy_in,         // quad i/o dummy clocks
    output logic [7:0]             rd_data_out,           // read byte
    output logic                   rd_valid_out,          // read byte valid
    input  wire logic              rd_ready_in,           // consumer takes byte
    output logic                   frame_done_out,        // pulse after a command ends
    output logic                   cont_mode_out,         // flash is in continuous-read mode
    output logic                   spi_cs_n_out,          // chip select, low active
    output logic                   spi_sck_out,           // serial clock
    input  wire logic [3:0]        spi_io_in,             // io3..io0 pin levels
    output logic [3:0]             spi_io_out,            // io3..io0 drive values
    output logic [3:0]             spi_io_oe_out          // io3..io0 drive enables
);
    import mfr_pkg::*;

    mfr_state_t  st_r, st_nxt;
    mfr_kind_t   kind_r, fk_r, crm_kind_r, sk;
    logic [4:0]  cnt_r, cnt_nxt, rest_r, mb_r, dc, mbk;
    logic [7:0]  div_r, rx_r, rx_nxt, skid_r;
    logic [31:0] sr_r, sr_nxt;
    logic [23:0] addr_r;
    logic [15:0] len_r, left_r;
    logic [3:0]  io_s1_r, io_s2_r;
    logic [2:0]  w_nxt;
    logic        cont_r, pend_r, exit_r, mode_a_r, crm_r, sck_r, skid_v_r, drive;
    logic        tick, active, rise, fall, stall, start, accept, exit_need, push, pop;

    function automatic logic [2:0] lane_w(input mfr_kind_t k);
        case (k)
            MFR_DUAL_IO: lane_w = 3'h2;
            MFR_QUAD_IO: lane_w = 3'h4;
            default:     lane_w = 3'h1;
        endcase
    endfunction

    function automatic logic [2:0] data_w(input mfr_kind_t k);
        data_w = (k == MFR_QUAD_IO || k == MFR_QUAD_OUT) ? 3'h4 : 3'h2;
    endfunction

    function automatic logic [4:0] beats_m1(input logic [4:0] nbits, input logic [2:0] w);
        case (w)
            3'h2:    beats_m1 = (nbits >> 1) - 5'h01;
            3'h4:    beats_m1 = (nbits >> 2) - 5'h01;
            default: beats_m1 = nbits - 5'h01;
        endcase
    endfunction

    function automatic logic [7:0] opcode(input mfr_kind_t k);
        case (k)
            MFR_DUAL_IO:  opcode = `MFR_OP_DUAL_IO;
            MFR_DUAL_OUT: opcode = `MFR_OP_DUAL_OUT;
            MFR_QUAD_OUT: opcode = `MFR_OP_QUAD_OUT;
            default:      opcode = `MFR_OP_QUAD_IO;
        endcase
    endfunction

    // top bits of the shifter onto lanes: io1 before io0, io3 first on quad
    function automatic logic [3:0] lane_bits(input logic [31:0] sr, input logic [2:0] w);
        case (w)
            3'h2:    lane_bits = {2'h0, sr[31], sr[30]};
            3'h4:    lane_bits = sr[31:28];
            default: lane_bits = {3'h0, sr[31]};
        endcase
    endfunction

    function automatic logic [3:0] lane_oe(input logic [2:0] w);
        case (w)
            3'h2:    lane_oe = 4'h3;
            3'h4:    lane_oe = 4'hf;
            default: lane_oe = 4'h1;
        endcase
    endfunction

    // strobes; a kind change while the flash sits in continuous mode needs an exit frame first
    assign accept    = cmd_valid_in && cmd_ready_out;
    assign start     = st_r == MFR_IDLE && pend_r;
    assign exit_need = crm_r && kind_r != crm_kind_r;
    assign sk        = exit_need ? crm_kind_r : kind_r;
    assign dc        = {1'b0, (sk == MFR_DUAL_IO) ? dual_dummy_in : quad_dummy_in};
    assign mbk       = beats_m1(`MFR_MODE_BITS, lane_w(sk)) + 5'h01;
    assign tick      = div_r == 8'(SCK_HALF - 1);
    assign active    = st_r != MFR_IDLE && st_r != MFR_END;
    assign rise      = tick && !sck_r && active;
    assign fall      = tick && sck_r;
    // sck is parked low at a byte boundary while the buffer is full, so no byte is lost
    assign stall     = st_r == MFR_DATA && !sck_r && skid_v_r && cnt_r == beats_m1(5'h08, data_w(fk_r));
    assign push      = rise && st_r == MFR_DATA && cnt_r == 5'h00;
    assign pop       = rd_valid_out && rd_ready_in;

    // pin synchroniser; only the second stage is read
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
        if (sys_rst_in)
        begin
            io_s1_r <= 4'h0;
            io_s2_r <= 4'h0;
        end
        else if (clk_en_in)
        begin
            io_s1_r <= spi_io_in;
            io_s2_r <= io_s1_r;
        end

    // sck divider and pin strobes
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
        if (sys_rst_in)
        begin
            div_r        <= 8'h00;
            sck_r        <= 1'b0;
            spi_sck_out  <= 1'b0;
            spi_cs_n_out <= 1'b1;
        end
        else if (clk_en_in)
        begin
            div_r <= (st_r == MFR_IDLE || stall || tick) ? 8'h00 : div_r + 8'h01;
            if (rise)
                sck_r <= 1'b1;
            else if (fall || start)
                sck_r <= 1'b0;
            spi_sck_out <= rise ? 1'b1 : ((fall || start) ? 1'b0 : sck_r);
            if (start)
                spi_cs_n_out <= 1'b0;
            else if (fall && st_nxt == MFR_END)
                spi_cs_n_out <= 1'b1;
        end

    // frame sequencing, phase changes on the falling sck edge
    always_comb
    begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            MFR_IDLE:
            begin
                if (start)
                begin
                    st_nxt  = crm_r ? MFR_ADDR : MFR_CMD;
                    cnt_nxt = crm_r ? beats_m1(`MFR_ADDR_BITS, lane_w(sk)) : beats_m1(`MFR_OPC_BITS, 3'h1);
                end
            end
            MFR_END:
            begin
                if (tick)
                    st_nxt = MFR_IDLE;
            end
            default:
            begin
                if (fall)
                begin
                    cnt_nxt = cnt_r - 5'h01;
                    if (cnt_r == 5'h00)
                    begin
                        case (st_r)
                            MFR_CMD:
                            begin
                                st_nxt  = MFR_ADDR;
                                cnt_nxt = beats_m1(`MFR_ADDR_BITS, lane_w(fk_r));
                            end
                            MFR_ADDR:
                            begin
                                st_nxt  = (lane_w(fk_r) != 3'h1) ? MFR_MODE : MFR_DUMMY;
                                cnt_nxt = (lane_w(fk_r) != 3'h1) ? beats_m1(`MFR_MODE_BITS, lane_w(fk_r))
                                                                 : `MFR_OUT_DUMMY - 5'h01;
                            end
                            MFR_MODE:
                            begin
                                // mode clocks are counted inside the dummy count
                                st_nxt  = (rest_r != 5'h00) ? MFR_DUMMY : ((left_r != 16'h0000) ? MFR_DATA : MFR_END);
                                cnt_nxt = (rest_r != 5'h00) ? rest_r - 5'h01 : beats_m1(5'h08, data_w(fk_r));
                            end
                            MFR_DUMMY:
                            begin
                                st_nxt  = (left_r != 16'h0000) ? MFR_DATA : MFR_END;
                                cnt_nxt = beats_m1(5'h08, data_w(fk_r));
                            end
                            default:
                            begin
                                st_nxt  = (left_r != 16'h0000) ? MFR_DATA : MFR_END;
                                cnt_nxt = beats_m1(5'h08, data_w(fk_r));
                            end
                        endcase
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
        if (sys_rst_in)
        begin
            st_r  <= MFR_IDLE;
            cnt_r <= 5'h00;
        end
        else if (clk_en_in)
        begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
        end

    // command latch, frame setup and handshake
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
        if (sys_rst_in)
        begin
            kind_r <= MFR_DUAL_IO;
            fk_r <= MFR_DUAL_IO;
            addr_r <= 24'h000000;
            len_r <= 16'h0000;
            left_r <= 16'h0000;
            cont_r <= 1'b0;
            pend_r <= 1'b0;
            exit_r <= 1'b0;
            mode_a_r <= 1'b0;
            rest_r <= 5'h00;
            mb_r <= 5'h00;
            cmd_ready_out <= 1'b0;
            frame_done_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (accept)
            begin
                kind_r <= cmd_kind_in;
                addr_r <= cmd_addr_in;
                len_r  <= cmd_len_in;
                cont_r <= cmd_cont_in;
                pend_r <= 1'b1;
            end
            else if (start)
            begin
                fk_r     <= sk;
                exit_r   <= exit_need;
                mode_a_r <= !exit_need && cont_r;
                left_r   <= exit_need ? 16'h0000 : len_r;
                mb_r     <= mbk;
                rest_r   <= (dc > mbk) ? dc - mbk : 5'h00;
                pend_r   <= exit_need;
            end
            else if (push)
                left_r <= left_r - 16'h0001;
            cmd_ready_out  <= st_r == MFR_IDLE && !pend_r && !accept;
            frame_done_out <= st_r == MFR_END && tick && !exit_r;
        end

    // continuous-read tracking: the line mode itself never changes here
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
        if (sys_rst_in)
        begin
            crm_r      <= 1'b0;
            crm_kind_r <= MFR_DUAL_IO;
        end
        else if (clk_en_in && fall && st_nxt == MFR_END && lane_w(fk_r) != 3'h1)
        begin
            crm_r      <= mode_a_r;
            crm_kind_r <= fk_r;
        end
    assign cont_mode_out = crm_r;

    // transmit shifter and lane drive; lower mode lines float when dummies equal mode clocks
    always_comb
    begin
        sr_nxt = sr_r;
        if (start)
            sr_nxt = crm_r ? {addr_r, 8'h00} : {opcode(sk), addr_r};
        else if (fall && st_r == MFR_ADDR && cnt_r == 5'h00)
            sr_nxt = {mode_a_r ? `MFR_MODE_CONT : `MFR_MODE_EXIT, 4'h0, 24'h000000};
        else if (fall)
            sr_nxt = sr_r << ((st_r == MFR_CMD) ? 3'h1 : lane_w(fk_r));
        w_nxt = (st_nxt == MFR_CMD) ? 3'h1 : lane_w(start ? sk : fk_r);
        drive = st_nxt == MFR_CMD || st_nxt == MFR_ADDR ||
                (st_nxt == MFR_MODE && !(rest_r == 5'h00 && cnt_nxt < (mb_r >> 1)));
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
        if (sys_rst_in)
        begin
            sr_r          <= 32'h00000000;
            spi_io_out    <= 4'h0;
            spi_io_oe_out <= 4'h0;
        end
        else if (clk_en_in)
        begin
            sr_r          <= sr_nxt;
            spi_io_out    <= drive ? lane_bits(sr_nxt, w_nxt) : 4'h0;
            spi_io_oe_out <= drive ? lane_oe(w_nxt) : 4'h0;
        end

    // receive: sampled at the rising edge, half a period after the flash shifted on falling
    assign rx_nxt = (data_w(fk_r) == 3'h2) ? {rx_r[5:0], io_s2_r[1:0]} : {rx_r[3:0], io_s2_r[3:0]};
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
        if (sys_rst_in)
            rx_r <= 8'h00;
        else if (clk_en_in && rise && st_r == MFR_DATA)
            rx_r <= rx_nxt;

    // two-entry buffer: output register plus skid slot
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
        if (sys_rst_in)
        begin
            rd_data_out  <= 8'h00;
            rd_valid_out <= 1'b0;
            skid_r       <= 8'h00;
            skid_v_r     <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (!rd_valid_out || pop)
            begin
                if (skid_v_r)
                begin
                    rd_data_out <= skid_r;
                    skid_r      <= rx_nxt;
                    skid_v_r    <= push;
                end
                else
                begin
                    rd_data_out  <= push ? rx_nxt : rd_data_out;
                    rd_valid_out <= push;
                end
            end
            else if (push)
            begin
                skid_r   <= rx_nxt;
                skid_v_r <= 1'b1;
            end
        end

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence end_entry;
        st_r != MFR_END ##1 st_r == MFR_END;
    endsequence
    cs_release_a: assert property (end_entry |-> spi_cs_n_out && !spi_sck_out ##[1:16] st_r == MFR_IDLE)
        else $error("chip select not released at frame end");
    serial_lane_a: assert property (st_r == MFR_CMD |-> spi_io_oe_out == 4'h1)
        else $error("opcode not on io0 alone");
    dual_addr_a: assert property ($rose(st_r == MFR_ADDR) && fk_r == MFR_DUAL_IO |-> cnt_r == 5'h0b && spi_io_oe_out == 4'h3)
        else $error("dual address phase length or lanes wrong");
    // lanes hold the address pair that the beat counter points at, io1 carrying the upper bit
    dual_lanes_a: assert property (st_r == MFR_ADDR && fk_r == MFR_DUAL_IO
                                   |-> spi_io_out[1:0] == addr_r[{cnt_r[3:0], 1'b1} -: 2])
        else $error("dual address bit order wrong");
    quad_addr_a: assert property ($rose(st_r == MFR_ADDR) && fk_r == MFR_QUAD_IO |-> cnt_r == 5'h05 && spi_io_oe_out == 4'hf)
        else $error("quad address phase length or lanes wrong");
    mode_upper_a: assert property (st_r == MFR_MODE && fk_r == MFR_DUAL_IO && cnt_r > 5'h01
                                   |-> spi_io_out[1:0] == {mode_a_r, 1'b0} && spi_io_oe_out == 4'h3)
        else $error("dual mode nibble wrong");
    lower_float_a: assert property (st_r == MFR_MODE && rest_r == 5'h00 && cnt_r < (mb_r >> 1) |-> spi_io_oe_out == 4'h0)
        else $error("lower mode lines still driven");
    quad_mode_a: assert property ($rose(st_r == MFR_MODE) && fk_r == MFR_QUAD_IO |-> cnt_r == 5'h01 ##1 spi_io_oe_out == 4'hf)
        else $error("quad mode phase wrong");
    out_dummy_a: assert property ($rose(st_r == MFR_DUMMY) && lane_w(fk_r) == 3'h1 |-> cnt_r == 5'h07 && spi_io_oe_out == 4'h0)
        else $error("output read dummy wrong");
    dummy_tail_a: assert property ($rose(st_r == MFR_DUMMY) && fk_r == MFR_QUAD_IO
                                   |-> cnt_r == {1'b0, quad_dummy_in} - 5'h03)
        else $error("dummy remainder wrong");
endmodule

// *** core/mfr_regs.svh ***
/*
  constants of the multi-lane fast-read host: opcodes, mode nibbles, phase lengths, defaults.
  assumes it is included by bare name from the design files.
*/
`ifndef MFR_REGS_SVH
`define MFR_REGS_SVH
`define MFR_OP_DUAL_IO       8'hbb
`define MFR_OP_DUAL_OUT      8'h3b
`define MFR_OP_QUAD_OUT      8'h6b
`define MFR_OP_QUAD_IO       8'heb
`define MFR_MODE_CONT        4'ha
`define MFR_MODE_EXIT        4'h0
`define MFR_OPC_BITS         5'h08
`define MFR_ADDR_BITS        5'h18
`define MFR_MODE_BITS        5'h08
`define MFR_OUT_DUMMY        5'h08
`define MFR_DUAL_DUMMY_DEF   4'h4
`define MFR_QUAD_DUMMY_DEF   4'h6
`define MFR_SCK_HALF_DEF     4
`endif

// *** core/mfr_pkg.sv ***
/*
  types of the multi-lane fast-read host: read kinds and frame states.
  assumes nothing beyond a SystemVerilog compiler.
*/
package mfr_pkg;
    typedef enum logic [1:0] {
        MFR_DUAL_IO  = 2'h0,
        MFR_DUAL_OUT = 2'h1,
        MFR_QUAD_OUT = 2'h2,
        MFR_QUAD_IO  = 2'h3
    } mfr_kind_t;

    typedef enum logic [6:0] {
        MFR_IDLE  = 7'h01,
        MFR_CMD   = 7'h02,
        MFR_ADDR  = 7'h04,
        MFR_MODE  = 7'h08,
        MFR_DUMMY = 7'h10,
        MFR_DATA  = 7'h20,
        MFR_END   = 7'h40
    } mfr_state_t;
endpackage

// *** testbench/mfr_flash_model.sv ***
/*
  behavioural serial flash: the four fast reads with continuous-read mode.
  assumes mode-0 sck from the host and resolved io levels from the bench.
*/
`timescale 1ns/1ps
`include "mfr_regs.svh"
module mfr_flash_model (
    input  wire logic       spi_cs_n_in,   // chip select, low active
    input  wire logic       spi_sck_in,    // serial clock from host
    input  wire logic [3:0] spi_io_in,     // resolved io levels
    input  wire logic [3:0] dual_dummy_in, // dual i/o dummy clocks
    input  wire logic [3:0] quad_dummy_in, // quad i/o dummy clocks
    input  wire logic       wip_in,        // internal write busy
    output logic [3:0]      dev_io_out,    // drive values
    output logic [3:0]      dev_oe_out     // drive enables
);
    logic [7:0]  op_r;
    logic [7:0]  mode_r;
    logic [23:0] addr_r;
    logic        cont_r;
    logic        skip_r;
    logic [7:0]  b;
    int          cnt, base, al, ac, mc, dc, dl, d;

    initial
    begin
        {op_r, mode_r, addr_r, cont_r, skip_r, dev_io_out, dev_oe_out} = '0;
        cnt  = 0;
        base = 8;
    end
    // lane counts and phase lengths of the held opcode
    always @*
    begin
        al = (op_r == `MFR_OP_DUAL_IO) ? 2 : (op_r == `MFR_OP_QUAD_IO) ? 4 : 1;
        dl = (op_r == `MFR_OP_DUAL_IO || op_r == `MFR_OP_DUAL_OUT) ? 2 : 4;
        ac = 24 / al;
        mc = (al == 1) ? 0 : 8 / al;
        dc = (al == 2) ? int'(dual_dummy_in) : (al == 4) ? int'(quad_dummy_in) : 8;
        if (dc < mc)
            dc = mc;
    end
    // frame start: continuous mode skips the opcode; busy array ignores the frame
    always @(negedge spi_cs_n_in)
    begin
        cnt    = 0;
        base   = cont_r ? 0 : 8;
        skip_r = wip_in;
    end
    // raising chip select releases the lines
    always @(posedge spi_cs_n_in)
        dev_oe_out = 4'h0;
    // sample on rising sck; only the continuous flag changes, no line-mode state
    always @(posedge spi_sck_in)
    begin
        if (!spi_cs_n_in && !skip_r)
        begin
            if (cnt < base)
                op_r = {op_r[6:0], spi_io_in[0]};
            else if (cnt < base + ac)
                addr_r = (al == 4) ? {addr_r[19:0], spi_io_in} :
                         (al == 2) ? {addr_r[21:0], spi_io_in[1:0]} : {addr_r[22:0], spi_io_in[0]};
            else if (cnt < base + ac + mc)
                mode_r = (al == 4) ? {mode_r[3:0], spi_io_in} : {mode_r[5:0], spi_io_in[1:0]};
            cnt = cnt + 1;
            if (mc != 0 && cnt == base + ac + mc)
                cont_r = (mode_r[7:4] == `MFR_MODE_CONT);
        end
    end
    // drive data on falling sck; address advances per byte and wraps at 24 bits
    always @(negedge spi_sck_in)
    begin
        if (!spi_cs_n_in && !skip_r && cnt >= base + ac + dc)
        begin
            d = cnt - (base + ac + dc);
            b = mem(addr_r + 24'(d / (8 / dl)));
            dev_io_out = (dl == 2) ? {2'b00, 2'(b >> (6 - 2 * (d % 4)))} : 4'(b >> (4 - 4 * (d % 2)));
            dev_oe_out = (dl == 2) ? 4'h3 : 4'hf;
        end
    end
    function automatic logic [7:0] mem(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3c;
    endfunction
endmodule

// *** testbench/testbench.sv ***
/*
  self-checking bench of the fast-read host against the flash model.
  assumes the host's default sck divider and mfr_flash_model on the same pins.
*/
`timescale 1ns/1ps
module testbench;
    import mfr_pkg::*;
    logic        sys_clk, sys_rst, cmd_valid, cmd_cont, rd_ready, cmd_ready_out, rd_valid_out, write_in_progress_flag;
    logic        frame_done_out, cont_mode_out, spi_cs_n_out, spi_sck_out;
    mfr_kind_t   cmd_kind;
    logic [23:0] cmd_addr;
    logic [15:0] cmd_len;
    logic [3:0]  dual_dummy, quad_dummy, spi_io_out, spi_io_oe_out, dev_io, dev_oe, io_w;
    logic [7:0]  rd_data_out;
    int          failures, checks_done, clash;

    // pull-ups win where nobody drives
    assign io_w = (spi_io_oe_out & spi_io_out) | (~spi_io_oe_out & dev_oe & dev_io) | (~spi_io_oe_out & ~dev_oe);
    mfr_host i_dut (.sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .clk_en_in(1'b1), .cmd_valid_in(cmd_valid),
        .cmd_ready_out(cmd_ready_out), .cmd_kind_in(cmd_kind), .cmd_addr_in(cmd_addr), .cmd_len_in(cmd_len),
        .cmd_cont_in(cmd_cont), .dual_dummy_in(dual_dummy), .quad_dummy_in(quad_dummy),
        .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready),
        .frame_done_out(frame_done_out), .cont_mode_out(cont_mode_out), .spi_cs_n_out(spi_cs_n_out),
        .spi_sck_out(spi_sck_out), .spi_io_in(io_w), .spi_io_out(spi_io_out), .spi_io_oe_out(spi_io_oe_out));
    mfr_flash_model i_flash (.spi_cs_n_in(spi_cs_n_out), .spi_sck_in(spi_sck_out), .spi_io_in(io_w),
        .dual_dummy_in(dual_dummy), .quad_dummy_in(quad_dummy), .wip_in(write_in_progress_flag), .dev_io_out(dev_io),
        .dev_oe_out(dev_oe));

    // 10 mhz clock
    always #50 sys_clk = ~sys_clk;
    // both sides driving one lane is a contention
    always @(posedge sys_clk)
        if (|(spi_io_oe_out & dev_oe))
            clash++;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic tick(inout int t);
        @(posedge sys_clk);
        t++;
        if (t > 20000)
        begin
            failures++;
            $display("[ERR] t=%0t wait limit hit", $time);
            print_verdict();
        end
    endtask
    // one command, bytes checked against the array, end state checked
    task automatic read_frame(input mfr_kind_t k, input logic [23:0] addr, input int len, input logic cont,
                              input logic exp_cont, input int stall);
        int          n;
        int          t;
        logic [23:0] a;
        n = 0;
        t = 0;
        @(posedge sys_clk);
        cmd_kind  <= k;
        cmd_addr  <= addr;
        cmd_len   <= 16'(len);
        cmd_cont  <= cont;
        cmd_valid <= 1'b1;
        rd_ready  <= (stall == 0);
        do
            tick(t);
        while (cmd_ready_out !== 1'b1);
        cmd_valid <= 1'b0;
        while (n < len)
        begin
            tick(t);
            if (t == stall - 1)
                check({spi_cs_n_out, spi_sck_out, rd_valid_out}, 3'h1);
            if (t == stall)
                rd_ready <= 1'b1;
            if (rd_valid_out === 1'b1 && rd_ready === 1'b1)
            begin
                a = addr + 24'(n);
                check(rd_data_out, write_in_progress_flag ? 8'hff : (a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3c));
                n++;
            end
        end
        while (frame_done_out !== 1'b1)
            tick(t);
        check({cont_mode_out, i_flash.cont_r}, {2{exp_cont}});
    endtask

    // every kind with default dummies
    task automatic s_kinds();
        for (int k = 0; k < 4; k++)
            read_frame(mfr_kind_t'(k), 24'h123456, 3, 1'b0, 1'b0, 0);
    endtask
    // stream across the top of the array
    task automatic s_wrap();
        read_frame(MFR_DUAL_OUT, 24'hfffffe, 4, 1'b0, 1'b0, 0);
    endtask
    // enter, stay in and leave continuous-read mode on dual i/o
    task automatic s_cont_dual();
        read_frame(MFR_DUAL_IO, 24'h00a0f0, 2, 1'b1, 1'b1, 0);
        read_frame(MFR_DUAL_IO, 24'h3c0001, 2, 1'b1, 1'b1, 0);
        read_frame(MFR_DUAL_IO, 24'h800000, 2, 1'b0, 1'b0, 0);
        read_frame(MFR_DUAL_IO, 24'h000010, 1, 1'b0, 1'b0, 0);
    endtask
    // quad continuous mode, then a different kind forces an exit
    task automatic s_cont_switch();
        read_frame(MFR_QUAD_IO, 24'h5a5a5a, 3, 1'b1, 1'b1, 0);
        read_frame(MFR_QUAD_IO, 24'h000100, 2, 1'b1, 1'b1, 0);
        read_frame(MFR_DUAL_IO, 24'h654321, 2, 1'b0, 1'b0, 0);
    endtask
    // receiver stalls: buffer fills, sck stops, no byte lost
    task automatic s_stall();
        read_frame(MFR_QUAD_OUT, 24'h0abcde, 6, 1'b0, 1'b0, 1500);
    endtask
    // busy flash ignores the read: lines float to the pull-ups, next read is normal
    task automatic s_busy();
        write_in_progress_flag <= 1'b1;
        read_frame(MFR_DUAL_OUT, 24'h0c0c0c, 2, 1'b0, 1'b0, 0);
        write_in_progress_flag <= 1'b0;
        read_frame(MFR_DUAL_OUT, 24'h0c0c0c, 1, 1'b0, 1'b0, 0);
    endtask
    // other dummy settings, including dummy equal to mode clocks
    task automatic s_dummy();
        dual_dummy <= 4'h6;
        quad_dummy <= 4'h2;
        read_frame(MFR_DUAL_IO, 24'h111111, 2, 1'b1, 1'b1, 0);
        read_frame(MFR_QUAD_IO, 24'h222222, 2, 1'b0, 1'b0, 0);
        dual_dummy <= 4'h4;
        quad_dummy <= 4'h6;
        read_frame(MFR_QUAD_IO, 24'h333333, 2, 1'b0, 1'b0, 0);
    endtask

    initial
    begin
        {sys_clk, cmd_valid, cmd_cont, rd_ready, write_in_progress_flag, failures, checks_done, clash} = '0;
        sys_rst    = 1'b1;
        cmd_kind   = MFR_DUAL_IO;
        cmd_addr   = 24'h000000;
        cmd_len    = 16'h0000;
        dual_dummy = 4'h4;
        quad_dummy = 4'h6;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        check({spi_cs_n_out, spi_sck_out, spi_io_oe_out, cont_mode_out}, 7'h40);
        s_kinds();
        s_wrap();
        s_cont_dual();
        s_cont_switch();
        s_stall();
        s_busy();
        s_dummy();
        check(clash, 0);
        print_verdict();
    end
endmodule
